// [hw/sms_pkg.sv]
/*
  shared constants for the serial master/slave core: register map, control
  and status bit positions, rate dividers, pin indexes and the state type.
  assumes a single 125 MHz bus clock and word-aligned AHB-Lite access.
*/
package sms_pkg;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam int CTRL_RATE_LO = 0;
  localparam int CTRL_RATE_HI = 1;
  localparam int CTRL_CPHA = 2;
  localparam int CTRL_CPOL = 3;
  localparam int CTRL_MSTR = 4;
  localparam int CTRL_EN = 5;
  localparam int CTRL_TXIE = 6;
  localparam int CTRL_RXIE = 7;
  localparam int STAT_TXE = 0;
  localparam int STAT_RXF = 1;
  localparam int STAT_BUSY = 2;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic TXE_RST = 1'b1;
  localparam logic [6:0] HALF_DIV2 = 7'h01;
  localparam logic [6:0] HALF_DIV8 = 7'h04;
  localparam logic [6:0] HALF_DIV32 = 7'h10;
  localparam logic [6:0] HALF_DIV128 = 7'h40;
  localparam logic [4:0] HALF_TICKS = 5'h10;
  localparam logic [3:0] XFER_BITS = 4'h8;
  localparam int PIN_SCLK = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_MISO = 2;
  localparam int PIN_SS = 3;
  localparam int NUM_PINS = 4;
  typedef enum logic {ST_IDLE = 1'b0, ST_ACTIVE = 1'b1} sms_state_e;
endpackage : sms_pkg

// [hw/sms_reg_if.sv]
/*
  register access carrier between the bus slave and the serial core.
  assumes wr and rd are one-cycle strobes qualified by addr.
*/
`timescale 1ns/10ps
interface sms_reg_if;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport bus (output wr, output rd, output addr, output wdata, input rdata);
  modport core (input wr, input rd, input addr, input wdata, output rdata);
endinterface : sms_reg_if

// [hw/sms_ahb_slave.sv]
/*
  AHB-Lite slave front end: writes take no wait state, reads take one so the
  read side effects and the returned byte see all earlier writes.
  assumes single word transfers, one slave on the bus, response always OKAY.
*/
`timescale 1ns/10ps
module sms_ahb_slave
  import sms_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  sms_reg_if.bus regs
);
  logic accept;
  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] addr_r;
  logic [31:0] hrdata_r;

  // htrans[1] covers NONSEQ and SEQ
  assign accept = i_hsel & i_hready & i_htrans[1];

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= BYTE_RST;
    end else begin
      wr_pend_r <= accept & i_hwrite;
      rd_pend_r <= accept & ~i_hwrite;
      if (accept) begin
        addr_r <= i_haddr[7:0];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_pend_r) begin
      hrdata_r <= {24'h00_0000, regs.rdata};
    end
  end

  assign regs.wr = wr_pend_r;
  assign regs.rd = rd_pend_r;
  assign regs.addr = addr_r;
  assign regs.wdata = i_hwdata[7:0];
  assign o_hrdata = hrdata_r;
  // one wait state on reads only
  assign o_hreadyout = ~rd_pend_r;
  assign o_hresp = 1'b0;
endmodule : sms_ahb_slave

// [hw/sms_spi_core.sv]
/*
  full-duplex serial core, master or slave, with buffered transmit and
  receive bytes, registers reached over AHB-Lite.
  assumes pins are joined to pads outside; all pin inputs are asynchronous.
*/
`timescale 1ns/10ps
module sms_spi_core
  import sms_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_serial_clock_pin,
  output logic o_serial_clock_pin,
  output logic o_serial_clock_oe,
  input wire logic i_mosi,
  output logic o_mosi,
  output logic o_mosi_oe,
  input wire logic i_miso,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic i_ss_n,
  output logic o_rx_irq,
  output logic o_tx_irq
);
  sms_reg_if regs ();

  sms_ahb_slave u_bus (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hwdata(i_hwdata),
    .i_hready(i_hready),
    .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp),
    .regs(regs.bus)
  );

  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] sync1_r;
  logic [NUM_PINS-1:0] sync2_r;
  logic [7:0] ctrl_r;
  logic [7:0] tx_buf_r;
  logic tx_empty_r;
  logic [7:0] rx_data_r;
  logic rx_full_r;
  logic armed_r;
  sms_state_e state_r;
  logic [7:0] shift_r;
  logic [7:0] rx_sh_r;
  logic [3:0] cap_cnt_r;
  logic [4:0] hcnt_r;
  logic [6:0] div_cnt_r;
  logic sclk_r;
  logic first_r;
  logic [1:0] mcap_p_r;
  logic sclk_d_r;
  logic ss_d_r;

  // hsize ignored: only whole-word access is supported
  logic unused_hsize;
  assign unused_hsize = ^i_hsize;

  // every pin input passes two flops before any logic sees it
  assign pin_raw = {i_ss_n, i_miso, i_mosi, i_serial_clock_pin};
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_sync
      always_ff @(posedge i_clk) begin
        // select resets to its idle high level so no false select edge follows reset
        if (!i_rst_n) begin
          sync1_r[g] <= (g == PIN_SS);
          sync2_r[g] <= (g == PIN_SS);
        end else begin
          sync1_r[g] <= pin_raw[g];
          sync2_r[g] <= sync1_r[g];
        end
      end
    end
  endgenerate

  // control fields
  logic [1:0] rate;
  logic cpha;
  logic cpol;
  logic mstr;
  logic en;
  assign rate = ctrl_r[CTRL_RATE_HI:CTRL_RATE_LO];
  assign cpha = ctrl_r[CTRL_CPHA];
  assign cpol = ctrl_r[CTRL_CPOL];
  assign mstr = ctrl_r[CTRL_MSTR];
  assign en = ctrl_r[CTRL_EN];

  // register decode
  logic sel_ctrl;
  logic sel_stat;
  logic sel_data;
  logic wr_ctrl;
  logic wr_data;
  logic rd_stat;
  logic rd_data;
  logic [7:0] stat_w;
  assign sel_ctrl = regs.addr == REG_CTRL;
  assign sel_stat = regs.addr == REG_STAT;
  assign sel_data = regs.addr == REG_DATA;
  assign wr_ctrl = regs.wr & sel_ctrl;
  assign wr_data = regs.wr & sel_data;
  assign rd_stat = regs.rd & sel_stat;
  assign rd_data = regs.rd & sel_data;

  always_comb begin
    stat_w = BYTE_RST;
    stat_w[STAT_TXE] = tx_empty_r;
    stat_w[STAT_RXF] = rx_full_r;
    stat_w[STAT_BUSY] = state_r == ST_ACTIVE;
  end

  // unmapped offsets read as zero
  assign regs.rdata = sel_ctrl ? ctrl_r : sel_stat ? stat_w : sel_data ? rx_data_r : BYTE_RST;

  // master rate: half period in bus cycles
  logic [6:0] half_lim;
  assign half_lim = rate[1] ? (rate[0] ? HALF_DIV128 : HALF_DIV32)
                            : (rate[0] ? HALF_DIV8 : HALF_DIV2);

  logic idle;
  logic active;
  logic m_act;
  logic s_act;
  assign idle = state_r == ST_IDLE;
  assign active = state_r == ST_ACTIVE;
  assign m_act = active & mstr;
  assign s_act = active & ~mstr;

  // master clock edges
  logic tick;
  logic m_lead;
  logic m_trail;
  assign tick = m_act & (div_cnt_r == half_lim - 7'h01) & (hcnt_r != HALF_TICKS);
  assign m_lead = tick & ~hcnt_r[0];
  assign m_trail = tick & hcnt_r[0];

  // slave edges, seen relative to the idle level
  logic sclk_a;
  logic ss_s;
  logic s_lead;
  logic s_trail;
  logic s_sel;
  logic s_start;
  assign sclk_a = sync2_r[PIN_SCLK] ^ cpol;
  assign ss_s = sync2_r[PIN_SS];
  assign s_lead = sclk_a & ~sclk_d_r;
  assign s_trail = ~sclk_a & sclk_d_r;
  assign s_sel = ~ss_s & en & ~mstr;
  // phase set: first clock edge starts; clear: select fall starts
  assign s_start = idle & s_sel & (cpha ? s_lead : (ss_d_r & ~ss_s));

  // common edge roles
  logic lead;
  logic trail;
  logic cap_raw;
  logic launch;
  logic cap;
  logic in_bit;
  assign lead = mstr ? m_lead : (s_lead & s_act);
  assign trail = mstr ? m_trail : (s_trail & s_act);
  // phase clear samples on the leading edge, MSB first
  assign cap_raw = cpha ? trail : lead;
  assign launch = cpha ? (lead & ~first_r) : trail;
  // master sample is delayed two cycles to cover the pin synchroniser
  assign cap = mstr ? mcap_p_r[1] : cap_raw;
  assign in_bit = mstr ? sync2_r[PIN_MISO] : sync2_r[PIN_MOSI];

  logic load;
  logic m_start;
  logic done;
  logic abort;
  logic rx_clr;
  // a write sits in the buffer while active; shifter reloads only when idle
  assign load = idle & en & ~tx_empty_r;
  assign m_start = load & mstr;
  assign done = active & (cap_cnt_r == XFER_BITS) & (~mstr | (hcnt_r == HALF_TICKS));
  // a slave deselected mid-byte drops the byte
  assign abort = active & (~en | (~mstr & ss_s));
  assign rx_clr = rd_data & armed_r;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= regs.wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_buf_r <= BYTE_RST;
    end else if (wr_data) begin
      tx_buf_r <= regs.wdata;
    end
  end

  // a write in the same cycle as a load leaves the new byte pending
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_empty_r <= TXE_RST;
    end else if (wr_data) begin
      tx_empty_r <= 1'b0;
    end else if (load) begin
      tx_empty_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
    end else if (abort | done) begin
      state_r <= ST_IDLE;
    end else if (m_start | s_start) begin
      state_r <= ST_ACTIVE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      shift_r <= BYTE_RST;
    end else if (load) begin
      shift_r <= tx_buf_r;
    end else if (launch) begin
      shift_r <= {shift_r[6:0], 1'b0};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_sh_r <= BYTE_RST;
      cap_cnt_r <= 4'h0;
    end else if (m_start | s_start) begin
      rx_sh_r <= BYTE_RST;
      cap_cnt_r <= 4'h0;
    end else if (cap & active) begin
      rx_sh_r <= {rx_sh_r[6:0], in_bit};
      cap_cnt_r <= cap_cnt_r + 4'h1;
    end
  end

  // slave started by its own first edge has already passed it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      first_r <= 1'b0;
    end else if (m_start | s_start) begin
      first_r <= mstr;
    end else if (lead) begin
      first_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mcap_p_r <= 2'h0;
    end else begin
      mcap_p_r <= {mcap_p_r[0], m_act & cap_raw};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sclk_d_r <= 1'b0;
      ss_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_a;
      ss_d_r <= ss_s;
    end
  end

  // master baud divider restarts at each byte
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      div_cnt_r <= 7'h00;
    end else if (~m_act | tick) begin
      div_cnt_r <= 7'h00;
    end else begin
      div_cnt_r <= div_cnt_r + 7'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      hcnt_r <= 5'h00;
    end else if (m_start) begin
      hcnt_r <= 5'h00;
    end else if (tick) begin
      hcnt_r <= hcnt_r + 5'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sclk_r <= 1'b0;
    end else if (~m_act) begin
      sclk_r <= cpol;
    end else if (tick) begin
      sclk_r <= ~sclk_r;
    end
  end

  // a byte arriving as the flag clears is kept: set wins
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_data_r <= BYTE_RST;
      rx_full_r <= 1'b0;
    end else if (done & (~rx_full_r | rx_clr)) begin
      rx_data_r <= rx_sh_r;
      rx_full_r <= 1'b1;
    end else if (rx_clr) begin
      rx_full_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      armed_r <= 1'b0;
    end else if (rx_clr) begin
      armed_r <= 1'b0;
    end else if (rd_stat & rx_full_r) begin
      armed_r <= 1'b1;
    end
  end

  // pins; the master ignores its own select input
  assign o_serial_clock_pin = sclk_r;
  assign o_serial_clock_oe = en & mstr;
  assign o_mosi = shift_r[7];
  assign o_mosi_oe = en & mstr;
  assign o_miso = shift_r[7];
  assign o_miso_oe = s_sel;

  assign o_rx_irq = rx_full_r & ctrl_r[CTRL_RXIE];
  assign o_tx_irq = tx_empty_r & ctrl_r[CTRL_TXIE];
endmodule : sms_spi_core

// [tb/sms_spi_checker.sv]
/*
  port checker for the serial core.
  assumes it is bound to every sms_spi_core.
*/
`timescale 1ns/10ps
module sms_spi_checker (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic i_ss_n,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic o_serial_clock_oe,
  input wire logic o_mosi_oe,
  input wire logic o_miso_oe,
  input wire logic o_rx_irq,
  input wire logic o_tx_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire take_w = i_hsel && i_hready && i_htrans[1];
  a_bus_okay: assert property (o_hresp == 1'b0)
    else $error("bus response not okay");
  a_read_wait: assert property (take_w && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (take_w && i_hwrite |=> o_hreadyout)
    else $error("write stalled");
  a_rdata_byte: assert property (o_hrdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  a_pin_roles: assert property (o_serial_clock_oe == o_mosi_oe)
    else $error("clock and mosi drive differ");
  a_miso_role: assert property (o_miso_oe |-> !o_mosi_oe)
    else $error("miso driven in master mode");
  // synchroniser may add one cycle, so either depth is accepted
  a_miso_select: assert property (o_miso_oe |-> !$past(i_ss_n, 2) || !$past(i_ss_n, 3))
    else $error("miso driven while not selected");
  a_reset_quiet: assert property ($rose(i_rst_n) |-> !o_rx_irq && !o_tx_irq && !o_miso_oe)
    else $error("outputs active after reset");
  c_slave_sel: cover property ($rose(o_miso_oe));
  c_master_on: cover property ($rose(o_serial_clock_oe));
  c_rx_irq: cover property ($rose(o_rx_irq));
endmodule : sms_spi_checker
bind sms_spi_core sms_spi_checker sms_spi_checker_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready), .i_ss_n(i_ss_n), .o_hrdata(o_hrdata),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_serial_clock_oe(o_serial_clock_oe),
  .o_mosi_oe(o_mosi_oe), .o_miso_oe(o_miso_oe), .o_rx_irq(o_rx_irq), .o_tx_irq(o_tx_irq));

// [tb/sms_far_end.sv]
/*
  far side model: a slave answering the core's clock, or a master clocking it.
  assumes polarity 0 on both ends; the phase follows i_cpha.
*/
`timescale 1ns/10ps
module sms_far_end #(
  parameter int HALF = 6 // slow enough for the core's synchroniser
) (
  input wire logic i_clk,
  input wire logic i_master,
  input wire logic i_cpha,
  input wire logic i_go,
  input wire logic [7:0] i_tx,
  input wire logic i_sclk,
  input wire logic i_mosi,
  input wire logic i_miso,
  output logic o_sclk,
  output logic o_ss_n,
  output logic o_mosi,
  output logic o_miso,
  output logic o_done,
  output logic [7:0] o_rx
);
  logic [7:0] sh = 8'h00;
  logic [7:0] rx = 8'h00;
  int n = 0;
  initial begin
    o_sclk = 1'b0; // stands still at idle level between frames
    o_ss_n = 1'b1;
    o_done = 1'b0;
    o_rx = 8'h00;
  end
  assign o_miso = sh[7];
  assign o_mosi = sh[7];
  // same format as the core
  // phase clear: capture leading, shift trailing; phase set: shift leading but the first, capture trailing
  always @(posedge i_sclk) if (!i_master) begin
    if (!i_cpha) begin
      rx = {rx[6:0], i_mosi};
      n = n + 1;
    end else if (n != 0) begin
      sh = {sh[6:0], ~sh[0]};
    end
  end
  // the inverted fill keeps an idle line from repeating its last bit
  always @(negedge i_sclk) if (!i_master) begin
    if (i_cpha) begin
      rx = {rx[6:0], i_mosi};
      n = n + 1;
    end
    if (n == 8) begin
      n = 0;
      o_rx = rx;
      o_done = ~o_done;
      sh = i_tx;
    end else if (!i_cpha) begin
      sh = {sh[6:0], ~sh[0]};
    end
  end
  always @(posedge i_go) begin
    sh = i_tx;
    if (i_master) begin
      @(posedge i_clk);
      o_ss_n <= 1'b0; // low before and through the byte
      repeat (HALF) @(posedge i_clk);
      for (int i = 0; i < 8; i++) begin
        if (!i_cpha) begin
          rx = {rx[6:0], i_miso}; // msb sampled at first edge
        end else if (i != 0) begin
          sh <= {sh[6:0], ~sh[0]};
        end
        o_sclk <= 1'b1;
        repeat (HALF) @(posedge i_clk);
        if (i_cpha) begin
          rx = {rx[6:0], i_miso};
        end else begin
          sh <= {sh[6:0], ~sh[0]};
        end
        o_sclk <= 1'b0;
        repeat (HALF) @(posedge i_clk);
      end
      o_ss_n <= 1'b1; // raised again after each byte
      o_rx <= rx;
      o_done <= ~o_done;
    end
  end
endmodule : sms_far_end

// [tb/tb.sv]
/*
  testbench for the serial core: register map, master and slave transfers,
  rates and idle clock level.
  assumes a single bus slave; the far side is sms_far_end.
*/
`timescale 1ns/10ps
module tb
  import sms_pkg::*;
;
  typedef struct {string n; logic [31:0] v;} sms_exp_s;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, go = 0, fm = 0, fph = 0, tick = 0;
  logic [31:0] haddr = 0, hwdata = 0, val = 0;
  logic [1:0] htrans = 0;
  logic [7:0] ftx = 0;
  wire [31:0] hrdata;
  wire hrdy, hresp, sck_o, sck_oe, mo, mo_oe, mi, mi_oe, rxi, txi, f_sck, f_ss, f_mo, f_mi, f_done;
  wire [7:0] f_rx;
  wire sck_w = sck_oe ? sck_o : f_sck;
  wire mo_w = mo_oe ? mo : f_mo;
  wire mi_w = mi_oe ? mi : f_mi;
  sms_exp_s q[$];
  logic [7:0] fq[$];
  int n_mismatch = 0, checked = 0;
  always #4 clk = ~clk;
  sms_spi_core sms_spi_core_i (.i_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp), .i_serial_clock_pin(sck_w),
    .o_serial_clock_pin(sck_o), .o_serial_clock_oe(sck_oe), .i_mosi(mo_w), .o_mosi(mo), .o_mosi_oe(mo_oe),
    .i_miso(mi_w), .o_miso(mi), .o_miso_oe(mi_oe), .i_ss_n(f_ss), .o_rx_irq(rxi), .o_tx_irq(txi));
  sms_far_end sms_far_end_i (.i_clk(clk), .i_master(fm), .i_cpha(fph), .i_go(go), .i_tx(ftx), .i_sclk(sck_w),
    .i_mosi(mo_w), .i_miso(mi_w), .o_sclk(f_sck), .o_ss_n(f_ss), .o_mosi(f_mo), .o_miso(f_mi),
    .o_done(f_done), .o_rx(f_rx));
  always @(tick) if (q.size() > 0) begin
    checked++;
    if (q[0].v !== val) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", q[0].n, q[0].v, val);
    end
    void'(q.pop_front());
  end
  always @(f_done) if (fq.size() > 0) begin
    checked++;
    if (fq[0] !== f_rx) begin
      n_mismatch++;
      $display("CHECK FAILED far byte expected %h seen %h", fq[0], f_rx);
    end
    void'(fq.pop_front());
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task take(input string n, input logic [31:0] e, input logic [31:0] v);
    q.push_back('{n, e});
    val = v;
    tick = ~tick;
  endtask : take
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    take($sformatf("reg %h", a), e, hrdata);
  endtask : rd
  task wirq;
    for (int k = 0; k < 4000 && rxi !== 1'b1; k++) @(posedge clk);
  endtask : wirq
  task wfar;
    @(f_done);
    repeat (4) @(posedge clk);
  endtask : wfar
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    $display("watchdog expired");
    report_and_stop();
  end
  initial begin
    int hp[4];
    int k;
    logic [7:0] a, b, c, d;
    hp = '{1, 4, 16, 64};
    void'($urandom(32'h3b4c1ed2));
    a = 8'($urandom);
    b = 8'($urandom);
    c = 8'($urandom);
    d = 8'($urandom);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(REG_CTRL, 8'h00);
    rd(REG_STAT, 8'h01);
    rd(REG_DATA, 8'h00);
    wr(8'h0c, 8'hff);
    rd(8'h0c, 8'h00);
    rd(REG_CTRL, 8'h00);
    $display("test register map done");
    wr(REG_CTRL, 8'hb1); // master, divide by 8, rx irq on
    ftx = b;
    go <= 1'b1;
    fq.push_back(a); // sent msb first on mosi
    fq.push_back(c);
    wr(REG_DATA, a); // starts the byte
    ftx = d;
    go <= 1'b0;
    rd(REG_STAT, 8'h05);
    wr(REG_DATA, c);
    rd(REG_STAT, 8'h04);
    wirq();
    rd(REG_STAT, 8'h07);
    rd(REG_DATA, b);
    rd(REG_STAT, 8'h05);
    wirq();
    rd(REG_DATA, d);
    rd(REG_STAT, 8'h03);
    rd(REG_DATA, d);
    rd(REG_STAT, 8'h01);
    $display("test master done");
    wr(REG_CTRL, 8'h10); // master off before the far master takes over
    wr(REG_CTRL, 8'h80); // mode chosen before enable
    fm <= 1'b1;
    wr(REG_CTRL, 8'ha0);
    wr(REG_DATA, a);
    ftx = b;
    fq.push_back(a);
    fq.push_back(c);
    go <= 1'b1;
    repeat (30) @(posedge clk);
    wr(REG_DATA, c);
    go <= 1'b0;
    wfar();
    rd(REG_STAT, 8'h03);
    rd(REG_DATA, b);
    ftx = d;
    go <= 1'b1;
    wfar();
    go <= 1'b0;
    rd(REG_STAT, 8'h03);
    rd(REG_DATA, d);
    $display("test slave done");
    wr(REG_CTRL, 8'h00);
    fm <= 1'b0;
    for (int r = 0; r < 4; r++) begin
      wr(REG_CTRL, 8'h10 | r);
      wr(REG_CTRL, 8'h30 | r);
      fq.push_back(a);
      wr(REG_DATA, a);
      while (sck_o === 1'b0) @(posedge clk);
      k = 0;
      while (sck_o === 1'b1) begin
        @(posedge clk);
        k++;
      end
      take("half period", hp[r], k);
      wfar();
    end
    $display("test rates done");
    rd(REG_STAT, 8'h03); // rate bytes leave one unread byte, later ones dropped
    bus(1'b0, REG_DATA, 32'h0000_0000);
    wr(REG_CTRL, 8'h00);
    fph <= 1'b1;
    wr(REG_CTRL, 8'h15); // phase set while disabled
    wr(REG_CTRL, 8'hb5); // master, phase set, divide by 8
    ftx = c;
    go <= 1'b1;
    fq.push_back(b); // shift leading but the first, capture trailing
    wr(REG_DATA, b);
    go <= 1'b0;
    wirq();
    rd(REG_STAT, 8'h03);
    rd(REG_DATA, c);
    wr(REG_CTRL, 8'h00);
    fm <= 1'b1;
    wr(REG_CTRL, 8'h84);
    wr(REG_CTRL, 8'ha4);
    wr(REG_DATA, d);
    ftx = a;
    fq.push_back(d);
    go <= 1'b1;
    wfar();
    go <= 1'b0;
    rd(REG_STAT, 8'h03); // first clock edge started the byte
    rd(REG_DATA, a);
    $display("test phase done");
    wr(REG_CTRL, 8'h18); // polarity changed while disabled
    wr(REG_CTRL, 8'h78);
    repeat (3) @(posedge clk);
    take("idle clock", 1, sck_o);
    take("clock drive", 1, sck_oe);
    take("tx irq", 1, txi);
    $display("test polarity done");
    report_and_stop();
  end
endmodule : tb
